// ---- bench/ext_irq_ctrl_asserts.sv ----
// Purpose: port checks for ext_irq_ctrl
// Assumes: one clock domain, bound at the top ports
// Notes: shadows the protect, serial and key enable bits
`timescale 1ns/100ps
`default_nettype none
module ext_irq_ctrl_asserts
	import ext_irq_pkg::*;
(
	input wire logic	clk_in,		// clock
	input wire logic	nrst_in,	// reset
	input wire logic [15:0]	addr_in,	// address
	input wire logic [7:0]	wdata_in,	// write data
	input wire logic	wr_in,		// write strobe
	input wire logic	rd_in,		// read strobe
	input wire logic [7:0]	rdata_out,	// read data
	input wire logic [2:0]	ipl_in,		// cpu level
	input wire logic	ack_in,		// acknowledge
	input wire logic	swi_in,		// soft interrupt
	input wire logic	serial_tx_data_in,	// tx bit
	input wire logic	open_drain_select_in,	// od choice
	input wire logic	irq_req_out,	// request
	input wire logic [2:0]	irq_src_out,	// source
	input wire logic [2:0]	irq_level_out,	// level
	input wire logic	key_wake_out,	// key flag
	input wire logic [3:0]	ext_lowv_out,	// lowv bits
	input wire logic	serial_tx_pin_oe_out	// tx enable
);
	logic		prot_reg;	// stored protect bit
	logic		lvs_reg;	// stored serial lowv bit
	logic [7:0]	ken_reg;	// stored key enable
	wire logic	lv_wr = wr_in && addr_in == ADDR_LOWV_CONTROL;

	// shadow registers written like the design's
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			prot_reg <= 1'b0;
			lvs_reg <= 1'b0;
			ken_reg <= 8'h00;
		end
		else
		begin
			if (lv_wr)
				prot_reg <= wdata_in[LOWV_PROTECT_BIT];
			if (lv_wr && prot_reg)
				lvs_reg <= wdata_in[LOWV_SERIAL_BIT];
			if (wr_in && addr_in == ADDR_KEY_ENABLE)
				ken_reg <= wdata_in;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);

	sequence s_lv_wr;
		lv_wr;
	endsequence
	sequence s_take;
		ack_in && irq_req_out;
	endsequence

	property p_lowv_locked;
		s_lv_wr ##0 !prot_reg |=> $stable(ext_lowv_out);
	endproperty
	a_lowv_locked: assert property (p_lowv_locked) else $error("lowv moved while locked");
	property p_lowv_open;
		s_lv_wr ##0 prot_reg |=> {ext_lowv_out, 4'h0} == ($past(wdata_in) & 8'hf0);
	endproperty
	a_lowv_open: assert property (p_lowv_open) else $error("lowv bits not written");
	property p_tx_lv;
		serial_tx_data_in && lvs_reg |=> !serial_tx_pin_oe_out;
	endproperty
	a_tx_lv: assert property (p_tx_lv) else $error("tx driven high in lowv");
	property p_tx_ods;
		open_drain_select_in && serial_tx_data_in |=> !serial_tx_pin_oe_out;
	endproperty
	a_tx_ods: assert property (p_tx_ods) else $error("tx driven high in od");
	property p_ack_drop;
		s_take ##0 !swi_in |=> !irq_req_out;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("request kept after ack");
	property p_swi_keep;
		s_take ##0 swi_in ##1 $stable(ipl_in) |-> irq_req_out && $stable(irq_src_out);
	endproperty
	a_swi_keep: assert property (p_swi_keep) else $error("soft entry changed request");
	property p_level_win;
		irq_req_out |-> irq_level_out > $past(ipl_in);
	endproperty
	a_level_win: assert property (p_level_win) else $error("request not above ipl");
	property p_key_en;
		$rose(key_wake_out) |-> ken_reg[0] || ken_reg[2] || ken_reg[4] || ken_reg[6];
	endproperty
	a_key_en: assert property (p_key_en) else $error("key flag with no key enabled");
	property p_pinsel_mask;
		rd_in && addr_in == ADDR_PIN_SELECT |=> (rdata_out & ~PIN_SELECT_MASK) == 8'h00;
	endproperty
	a_pinsel_mask: assert property (p_pinsel_mask) else $error("pin select spare bit");
endmodule : ext_irq_ctrl_asserts
`default_nettype wire

// ---- bench/ext_irq_ctrl_tb.sv ----
// Purpose: self-checking bench for ext_irq_ctrl
// Assumes: pins come from ext_irq_pins_model
// Notes: random values from a fixed xorshift seed
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module ext_irq_ctrl_tb
	import ext_irq_pkg::*;
;
	logic clk_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, ack_in = 0, swi_in = 0, glitch = 0;
	logic serial_tx_data_in = 1, open_drain_select_in = 0, got;
	logic [15:0] addr_in = 16'h0000;
	logic [7:0] wdata_in = 8'h00, ext_lvl = 8'hff, v;
	logic [3:0] key_lvl = 4'b1101, pend;
	logic [2:0] ipl_in = 3'h0, w;
	logic [2:0] lv [4];
	wire logic [7:0] rdata_out, ext_irq_pin_in;
	wire logic [3:0] key_pin_in, ext_lowv_out;
	wire logic [2:0] irq_src_out, irq_level_out;
	wire logic irq_req_out, key_wake_out, serial_tx_pin_out, serial_tx_pin_oe_out;
	int bad_count = 0, checked = 0, cyc = 0, cnt, per;
	logic [31:0] seed = 32'h067598e6;
	logic [15:0] regs [6] = '{ADDR_PIN_SELECT, ADDR_LOWV_CONTROL, ADDR_INPUT_ENABLE,
		ADDR_FILTER_SELECT, ADDR_KEY_ENABLE, 16'h0100};
	logic [15:0] ctl [5] = '{ADDR_EXT0_CTRL, ADDR_EXT1_CTRL, ADDR_EXT2_CTRL,
		ADDR_EXT3_CTRL, ADDR_KEY_CTRL};

	ext_irq_ctrl dut (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.ext_irq_pin_in, .key_pin_in, .ipl_in, .ack_in, .swi_in, .serial_tx_data_in,
		.open_drain_select_in, .irq_req_out, .irq_src_out, .irq_level_out, .key_wake_out,
		.ext_lowv_out, .serial_tx_pin_out, .serial_tx_pin_oe_out);
	ext_irq_pins_model pins (.clk_in, .ext_lvl_in(ext_lvl), .key_lvl_in(key_lvl),
		.glitch_in(glitch), .ext_pin_out(ext_irq_pin_in), .key_pin_out(key_pin_in));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// highest level among pending, lowest number on a tie
	function automatic logic [2:0] winner();
		logic [2:0] b;
		b = 3'h0;
		for (int i = 3; i >= 0; i--)
			if (pend[i] && lv[i] >= b)
			begin
				b = lv[i];
				winner = 3'(i);
			end
	endfunction : winner
	task test_done();
		if (bad_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		@(posedge clk_in);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 `CHK(rdata_out, e)
		@(posedge clk_in);
	endtask : rd
	task automatic wait_req(input int n);
		got = 1'b0;
		cnt = 0;
		while (cnt < n && !got)
		begin
			@(posedge clk_in);
			cnt++;
			#1 got = (irq_req_out === 1'b1);
		end
	endtask : wait_req
	task automatic take(input logic [2:0] s, input logic [2:0] l);
		`CHK({irq_src_out, irq_level_out}, {s, l})
		ack_in <= 1'b1;
		@(posedge clk_in);
		ack_in <= 1'b0;
		#1 `CHK(irq_req_out, 1'b0)
		@(posedge clk_in);
	endtask : take

	// 20 MHz clock
	initial
	begin
		forever #25 clk_in = ~clk_in;
	end
	// hang guard
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			test_done();
		end
	end

	initial
	begin
		repeat (12) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		// reset values, unmapped place reads zero
		foreach (regs[i]) rd(regs[i], REG_RESET);
		// random write and readback of the plain registers
		for (int k = 0; k < 12; k++)
		begin
			v = 8'(rnd());
			wr(regs[k % 4 + (k % 4 > 0)], v);
			rd(regs[k % 4 + (k % 4 > 0)], k % 4 ? v : v & PIN_SELECT_MASK);
		end
		for (int k = 0; k < 5; k++)
			wr(k == 4 ? ctl[4] : regs[k % 4 + (k % 4 > 0)], 8'h00);
		// low-voltage bits locked, then opened by 0 then 1
		wr(ADDR_LOWV_CONTROL, 8'hf2);
		rd(ADDR_LOWV_CONTROL, 8'h00);
		wr(ADDR_LOWV_CONTROL, 8'h00);
		wr(ADDR_LOWV_CONTROL, 8'h01);
		wr(ADDR_LOWV_CONTROL, 8'hff);
		rd(ADDR_LOWV_CONTROL, 8'hf3);
		`CHK(ext_lowv_out, 4'hf)
		// serial pin drive with lowv on, then off
		for (int k = 0; k < 8; k++)
		begin
			if (k == 4)
				wr(ADDR_LOWV_CONTROL, 8'h01);
			{serial_tx_data_in, open_drain_select_in} <= 2'(rnd());
			repeat (2) @(posedge clk_in);
			#1 `CHK(serial_tx_pin_oe_out, ~((k < 4) | open_drain_select_in) | ~serial_tx_data_in)
			`CHK(serial_tx_pin_out, serial_tx_data_in)
		end
		// input 0: disabled, falling, rising, both edges
		for (int m = 0; m < 4; m++)
		begin
			wr(ctl[0], {3'h0, m == 2, 4'h3});
			wr(ADDR_INPUT_ENABLE, m == 0 ? 8'h00 : (m == 3 ? 8'h03 : 8'h01));
			for (int e = 0; e < 2; e++)
			begin
				ext_lvl[0] <= e[0];
				wait_req(8);
				`CHK(got, e ? m >= 2 : m % 2 == 1)
				if (got)
					take(3'h0, 3'h3);
			end
		end
		// filter: one-clock pulse refused, held level taken
		wr(ADDR_INPUT_ENABLE, 8'h01);
		for (int f = 1; f < 4; f++)
		begin
			per = f == 1 ? 1 : (f == 2 ? 8 : 32);
			wr(ADDR_FILTER_SELECT, 8'(f));
			glitch <= 1'b1;
			@(posedge clk_in);
			glitch <= 1'b0;
			wait_req(4 * per + 12);
			`CHK(got, 1'b0)
			ext_lvl[0] <= 1'b0;
			wait_req(4 * per + 12);
			`CHK(got && cnt >= 2 * per, 1'b1)
			if (got)
				take(3'h0, 3'h3);
			ext_lvl[0] <= 1'b1;
			repeat (4 * per + 12) @(posedge clk_in);
		end
		wr(ADDR_FILTER_SELECT, 8'h00);
		// input 1 from each of its three pins
		wr(ctl[1], 8'h04);
		for (int c = 0; c < 3; c++)
		begin
			wr(ADDR_INPUT_ENABLE, 8'h00);
			wr(ADDR_PIN_SELECT, 8'(c << 1));
			wr(ADDR_INPUT_ENABLE, 8'h04);
			ext_lvl[1 + (c + 1) % 3] <= 1'b0;
			wait_req(8);
			`CHK(got, 1'b0)
			ext_lvl[1 + c] <= 1'b0;
			wait_req(8);
			`CHK(got, 1'b1)
			if (got)
				take(3'h1, 3'h4);
			ext_lvl <= 8'hff;
			repeat (6) @(posedge clk_in);
		end
		// four inputs at once, random levels, masked then released
		wr(ADDR_PIN_SELECT, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			lv[i] = 3'(rnd() % 7 + 1);
			wr(ctl[i], {5'h00, lv[i]});
		end
		wr(ADDR_INPUT_ENABLE, 8'h55);
		ipl_in <= 3'h7;
		ext_lvl <= 8'hac;
		wait_req(10);
		`CHK(got, 1'b0)
		ipl_in <= 3'h0;
		pend = 4'hf;
		for (int i = 0; i < 4; i++)
		begin
			wait_req(6);
			if (i == 0)
			begin
				swi_in <= 1'b1;
				ack_in <= 1'b1;
				@(posedge clk_in);
				swi_in <= 1'b0;
				ack_in <= 1'b0;
				@(posedge clk_in);
				#1 `CHK(irq_req_out, 1'b1)
			end
			w = winner();
			take(w, lv[w]);
			pend[w] = 1'b0;
		end
		ext_lvl <= 8'hff;
		// writing one to a flag sets nothing
		wr(ctl[2], 8'h0b);
		wait_req(6);
		`CHK(got, 1'b0)
		// keys: disabled pin, falling key, held key blocks a rising one
		wr(ctl[4], 8'h01);
		wr(ADDR_KEY_ENABLE, 8'h0d);
		key_lvl <= 4'b1001;
		wait_req(8);
		`CHK(key_wake_out, 1'b0)
		key_lvl <= 4'b1000;
		wait_req(8);
		`CHK(key_wake_out, 1'b1)
		if (got)
			take(3'h4, 3'h1);
		key_lvl <= 4'b1010;
		wait_req(8);
		`CHK(key_wake_out, 1'b0)
		key_lvl <= 4'b1001;
		repeat (6) @(posedge clk_in);
		key_lvl <= 4'b1011;
		wait_req(8);
		`CHK(got, 1'b1)
		if (got)
			take(3'h4, 3'h1);
		test_done();
	end
endmodule : ext_irq_ctrl_tb

bind ext_irq_ctrl ext_irq_ctrl_asserts chk (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in,
	.rd_in, .rdata_out, .ipl_in, .ack_in, .swi_in, .serial_tx_data_in, .open_drain_select_in,
	.irq_req_out, .irq_src_out, .irq_level_out, .key_wake_out, .ext_lowv_out,
	.serial_tx_pin_oe_out);
`default_nettype wire

// ---- bench/ext_irq_pins_model.sv ----
// Purpose: external pin and key switch model
// Assumes: pins idle high unless the bench says otherwise
// Notes: glitch_in flips every ext pin for one clock
`timescale 1ns/100ps
`default_nettype none
module ext_irq_pins_model
(
	input  wire logic	clk_in,		// bench clock
	input  wire logic [7:0]	ext_lvl_in,	// wanted ext levels
	input  wire logic [3:0]	key_lvl_in,	// wanted key levels
	input  wire logic	glitch_in,	// one-clock flip
	output logic [7:0]	ext_pin_out,	// ext pins
	output logic [3:0]	key_pin_out	// key pins
);
	// pins follow the wanted levels one clock later
	always @(posedge clk_in)
	begin
		ext_pin_out <= glitch_in ? ~ext_lvl_in : ext_lvl_in;
		key_pin_out <= key_lvl_in;
	end
endmodule : ext_irq_pins_model
`default_nettype wire

// ---- common/ext_irq_pkg.sv ----
// Purpose: shared constants for the external and key input interrupt block
// Assumes: 8-bit registers on a 16-bit address port, 20 MHz peripheral clock
// Notes: control register offsets for the request lines are listed in the handover

package ext_irq_pkg;

	// register offsets
	localparam logic [15:0] ADDR_PIN_SELECT    = 16'h018e;
	localparam logic [15:0] ADDR_LOWV_CONTROL  = 16'h0190;
	localparam logic [15:0] ADDR_INPUT_ENABLE  = 16'h01fa;
	localparam logic [15:0] ADDR_FILTER_SELECT = 16'h01fc;
	localparam logic [15:0] ADDR_KEY_ENABLE    = 16'h01fe;
	localparam logic [15:0] ADDR_EXT0_CTRL     = 16'h005d;
	localparam logic [15:0] ADDR_EXT1_CTRL     = 16'h0059;
	localparam logic [15:0] ADDR_EXT2_CTRL     = 16'h0055;
	localparam logic [15:0] ADDR_EXT3_CTRL     = 16'h005a;
	localparam logic [15:0] ADDR_KEY_CTRL      = 16'h004d;

	// reset value shared by all registers
	localparam logic [7:0] REG_RESET = 8'h00;

	// request control register fields
	localparam int PRIO_LSB     = 0;
	localparam int PRIO_MSB     = 2;
	localparam int FLAG_BIT     = 3;
	localparam int EDGE_DIR_BIT = 4;

	// pin select fields
	localparam int ROUTE1_LSB = 1;
	localparam int ROUTE1_MSB = 3;
	localparam int ROUTE2_BIT = 4;
	localparam int ROUTE3_BIT = 6;
	localparam logic [7:0] PIN_SELECT_MASK = 8'h5e;

	// low-voltage control fields
	localparam int LOWV_PROTECT_BIT = 0;
	localparam int LOWV_SERIAL_BIT  = 1;
	localparam int LOWV_EXT_LSB     = 4;
	localparam int LOWV_EXT_MSB     = 7;

	// input 1 route codes
	localparam logic [2:0] ROUTE1_A = 3'h0;
	localparam logic [2:0] ROUTE1_B = 3'h1;
	localparam logic [2:0] ROUTE1_C = 3'h2;

	// raw pin vector positions
	localparam int PIN_EXT0   = 0;
	localparam int PIN_EXT1_A = 1;
	localparam int PIN_EXT1_B = 2;
	localparam int PIN_EXT1_C = 3;
	localparam int PIN_EXT2_A = 4;
	localparam int PIN_EXT2_B = 5;
	localparam int PIN_EXT3_A = 6;
	localparam int PIN_EXT3_B = 7;

	// filter select codes
	typedef enum logic [1:0]
	{
		FILT_NONE = 2'b00,
		FILT_F1   = 2'b01,
		FILT_F8   = 2'b10,
		FILT_F32  = 2'b11
	} filt_sel_t;

	// prescaler terminal counts for the sampling clocks
	localparam logic [4:0] F8_TERMINAL  = 5'h07;
	localparam logic [4:0] F32_TERMINAL = 5'h1f;

	// sources: 0..3 external inputs, 4 key input
	localparam int NUM_EXT = 4;
	localparam int NUM_SRC = 5;
	localparam int KEY_SRC = 4;
	localparam int FILTER_DEPTH = 3;

endpackage : ext_irq_pkg

// ---- verilog/ext_irq_ctrl.sv ----
// Purpose: external input and key input interrupt request logic with arbitration
// Assumes: pins are asynchronous; CPU gives ipl, ack and software interrupt strobes
// Notes: registers are 8 bits wide; read data appear one cycle after the strobe
//
// What this block does
// - each external input sets its request flag only while its enable bit is 1
// - both-edge select 0 uses one edge, 1 detects rising and falling
// - edge direction bit 0 picks falling edge, 1 picks rising edge
// - rewriting input enable sets no flag; only an edge on an enabled input does
// - filter field 00 none, 01 f1, 10 f8, 11 f32 sampling
// - filtered edge accepted only after three agreeing samples
// - pin select routes inputs 1 to 3 from alternative pins
// - low-voltage bits writable only while protect bit is 1
// - low-voltage bits 4 to 7 switch each input to CMOS threshold
// - serial low-voltage bit forces serial transmit pin to open drain
// - key pin edge raises key request and wakes the device
// - key pins have enable and polarity; 0 falling, 1 rising
// - an enabled key held active blocks requests from other key pins
// - highest programmed level wins; ties go by fixed hardware order
// - software interrupts bypass arbitration and clear no request flag
// - flags set by hardware, cleared by acknowledge; software writes 0 only
// - rewriting key enable may set key flag; software clears it

`timescale 1ns/100ps
`default_nettype none

module ext_irq_ctrl
	import ext_irq_pkg::*;
(
	input  wire logic        clk_in,            // 20 MHz peripheral clock
	input  wire logic        nrst_in,           // synchronous reset, active low
	input  wire logic [15:0] addr_in,           // register address
	input  wire logic [7:0]  wdata_in,          // register write data
	input  wire logic        wr_in,             // write strobe
	input  wire logic        rd_in,             // read strobe
	output logic      [7:0]  rdata_out,         // read data, cycle after rd_in
	input  wire logic [7:0]  ext_irq_pin_in,    // raw external pins, see package
	input  wire logic [3:0]  key_pin_in,        // raw key pins
	input  wire logic [2:0]  ipl_in,            // current cpu priority level
	input  wire logic        ack_in,            // cpu takes the presented request
	input  wire logic        swi_in,            // software interrupt being entered
	input  wire logic        serial_tx_data_in, // serial transmit bit
	input  wire logic        open_drain_select_in, // serial open-drain choice
	output logic             irq_req_out,       // a request beats ipl
	output logic      [2:0]  irq_src_out,       // winning source number
	output logic      [2:0]  irq_level_out,     // winning source level
	output logic             key_wake_out,      // key request pending, wakes cpu
	output logic      [3:0]  ext_lowv_out,      // per input CMOS threshold select
	output logic             serial_tx_pin_out, // serial transmit pin level
	output logic             serial_tx_pin_oe_out // serial transmit pin enable
);

	// decode one register address
	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction : hit

	// registers
	logic [7:0]  pin_sel_reg;
	logic [7:0]  lowv_reg;
	logic [7:0]  in_en_reg;
	logic [7:0]  filt_sel_reg;
	logic [7:0]  key_en_reg;
	logic [2:0]  prio_reg [NUM_SRC];
	logic [3:0]  edge_dir_reg;
	logic [NUM_SRC-1:0] flag_reg;
	logic [NUM_SRC-1:0] flag_next;
	logic [7:0]  rdata_reg;
	logic [7:0]  rd_next;
	logic [4:0]  presc_reg;
	logic [7:0]  pin_s1_reg;
	logic [7:0]  pin_s2_reg;
	logic [3:0]  key_s1_reg;
	logic [3:0]  key_s2_reg;
	logic [3:0]  ext_prev_reg;
	logic        key_act_prev_reg;
	logic        irq_req_reg;
	logic [2:0]  irq_src_reg;
	logic [2:0]  irq_lvl_reg;
	logic        tx_pin_reg;
	logic        tx_oe_reg;

	// address decode
	wire wr_pin   = wr_in & hit(addr_in, ADDR_PIN_SELECT);
	wire wr_lowv  = wr_in & hit(addr_in, ADDR_LOWV_CONTROL);
	wire wr_en    = wr_in & hit(addr_in, ADDR_INPUT_ENABLE);
	wire wr_filt  = wr_in & hit(addr_in, ADDR_FILTER_SELECT);
	wire wr_key   = wr_in & hit(addr_in, ADDR_KEY_ENABLE);
	wire [NUM_SRC-1:0] wr_ctrl;
	assign wr_ctrl[0] = wr_in & hit(addr_in, ADDR_EXT0_CTRL);
	assign wr_ctrl[1] = wr_in & hit(addr_in, ADDR_EXT1_CTRL);
	assign wr_ctrl[2] = wr_in & hit(addr_in, ADDR_EXT2_CTRL);
	assign wr_ctrl[3] = wr_in & hit(addr_in, ADDR_EXT3_CTRL);
	assign wr_ctrl[4] = wr_in & hit(addr_in, ADDR_KEY_CTRL);

	// sampling clock ticks from a free prescaler
	wire tick_f1  = 1'b1;
	wire tick_f8  = (presc_reg[2:0] == F8_TERMINAL[2:0]);
	wire tick_f32 = (presc_reg == F32_TERMINAL);

	// pin routing, unused route reads as idle high
	wire [2:0] route1 = pin_sel_reg[ROUTE1_MSB:ROUTE1_LSB];
	wire [3:0] ext_lvl;
	assign ext_lvl[0] = pin_s2_reg[PIN_EXT0];
	assign ext_lvl[1] = (route1 == ROUTE1_A) ? pin_s2_reg[PIN_EXT1_A] :
	                    (route1 == ROUTE1_B) ? pin_s2_reg[PIN_EXT1_B] :
	                    (route1 == ROUTE1_C) ? pin_s2_reg[PIN_EXT1_C] : 1'b1;
	assign ext_lvl[2] = pin_sel_reg[ROUTE2_BIT] ? pin_s2_reg[PIN_EXT2_B]
	                                            : pin_s2_reg[PIN_EXT2_A];
	assign ext_lvl[3] = pin_sel_reg[ROUTE3_BIT] ? pin_s2_reg[PIN_EXT3_B]
	                                            : pin_s2_reg[PIN_EXT3_A];

	// per input filter, selection and edge detection
	wire [3:0] ext_cur;
	wire [3:0] ext_evt;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EXT; gi++)
		begin : g_ext
			filt_sel_t fsel;
			logic      tick;
			logic      filt;
			logic      fall;
			logic      rise;
			assign fsel = filt_sel_t'(filt_sel_reg[2*gi+1:2*gi]);
			assign tick = (fsel == FILT_F1)  ? tick_f1 :
			              (fsel == FILT_F8)  ? tick_f8 :
			              (fsel == FILT_F32) ? tick_f32 : 1'b0;
			ext_irq_filter u_filt
			(
				.clk_in   (clk_in),
				.nrst_in  (nrst_in),
				.tick_in  (tick),
				.level_in (ext_lvl[gi]),
				.filt_out (filt)
			);
			assign ext_cur[gi] = (fsel == FILT_NONE) ? ext_lvl[gi] : filt;
			assign fall = ext_prev_reg[gi] & ~ext_cur[gi];
			assign rise = ~ext_prev_reg[gi] & ext_cur[gi];
			assign ext_evt[gi] = in_en_reg[2*gi] &
			                     (in_en_reg[2*gi+1] ? (fall | rise) :
			                      (edge_dir_reg[gi] ? rise : fall));
		end
	endgenerate

	// key inputs: polarity adjust and merge
	wire [3:0] key_act;
	wire       key_any;
	wire       key_evt;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_key
			assign key_act[gi] = key_en_reg[2*gi] &
			                     (key_en_reg[2*gi+1] ? key_s2_reg[gi] : ~key_s2_reg[gi]);
		end
	endgenerate
	assign key_any = |key_act;
	// a held key masks others; key edge event
	assign key_evt = key_any & ~key_act_prev_reg;

	// low-voltage protected write
	wire [7:0] lowv_wr_val;
	// protected bits follow only when protect is 1
	assign lowv_wr_val = lowv_reg[LOWV_PROTECT_BIT] ?
	                     {wdata_in[LOWV_EXT_MSB:LOWV_EXT_LSB], 2'b00,
	                      wdata_in[LOWV_SERIAL_BIT], wdata_in[LOWV_PROTECT_BIT]} :
	                     {lowv_reg[LOWV_EXT_MSB:LOWV_EXT_LSB], 2'b00,
	                      lowv_reg[LOWV_SERIAL_BIT], wdata_in[LOWV_PROTECT_BIT]};

	// request flags: set beats clear
	wire [NUM_SRC-1:0] flag_set = {key_evt, ext_evt};
	wire [NUM_SRC-1:0] sw_clr;
	wire [NUM_SRC-1:0] ack_clr;
	generate
		for (gi = 0; gi < NUM_SRC; gi++)
		begin : g_flag
			// software writes only 0; ack clears
			assign sw_clr[gi]  = wr_ctrl[gi] & ~wdata_in[FLAG_BIT];
			assign ack_clr[gi] = ack_in & ~swi_in & irq_req_reg &
			                     (irq_src_reg == 3'(gi));
			assign flag_next[gi] = flag_set[gi] |
			                       (flag_reg[gi] & ~sw_clr[gi] & ~ack_clr[gi]);
		end
	endgenerate

	// arbitration over pending requests
	logic       win_req;
	logic [2:0] win_src;
	logic [2:0] win_lvl;
	// highest level, lowest number on ties
	always_comb
	begin
		win_req = 1'b0;
		win_src = 3'h0;
		win_lvl = 3'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (flag_reg[i] && (prio_reg[i] > ipl_in) && (prio_reg[i] >= win_lvl))
			begin
				win_req = 1'b1;
				win_src = 3'(i);
				win_lvl = prio_reg[i];
			end
		end
	end

	// read data select
	always_comb
	begin
		rd_next = 8'h00;
		if (hit(addr_in, ADDR_PIN_SELECT))
			rd_next = pin_sel_reg;
		else if (hit(addr_in, ADDR_LOWV_CONTROL))
			rd_next = lowv_reg;
		else if (hit(addr_in, ADDR_INPUT_ENABLE))
			rd_next = in_en_reg;
		else if (hit(addr_in, ADDR_FILTER_SELECT))
			rd_next = filt_sel_reg;
		else if (hit(addr_in, ADDR_KEY_ENABLE))
			rd_next = key_en_reg;
		else
		begin
			for (int i = 0; i < NUM_SRC; i++)
			begin
				if (wr_ctrl[i] | (hit(addr_in, ADDR_EXT0_CTRL) && i == 0) |
				    (hit(addr_in, ADDR_EXT1_CTRL) && i == 1) |
				    (hit(addr_in, ADDR_EXT2_CTRL) && i == 2) |
				    (hit(addr_in, ADDR_EXT3_CTRL) && i == 3) |
				    (hit(addr_in, ADDR_KEY_CTRL) && i == KEY_SRC))
				begin
					rd_next[PRIO_MSB:PRIO_LSB] = prio_reg[i];
					rd_next[FLAG_BIT]          = flag_reg[i];
					rd_next[EDGE_DIR_BIT]      = (i < NUM_EXT) ? edge_dir_reg[i % NUM_EXT]
					                                           : 1'b0;
				end
			end
		end
	end

	// serial transmit pin drive
	wire tx_open_drain = lowv_reg[LOWV_SERIAL_BIT] | open_drain_select_in;

	// synchronisers, prescaler and edge history
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			pin_s1_reg       <= 8'hff;
			pin_s2_reg       <= 8'hff;
			key_s1_reg       <= 4'hf;
			key_s2_reg       <= 4'hf;
			presc_reg        <= 5'h00;
			ext_prev_reg     <= 4'hf;
			key_act_prev_reg <= 1'b0;
		end
		else
		begin
			pin_s1_reg       <= ext_irq_pin_in;
			pin_s2_reg       <= pin_s1_reg;
			key_s1_reg       <= key_pin_in;
			key_s2_reg       <= key_s1_reg;
			presc_reg        <= presc_reg + 5'h01;
			ext_prev_reg     <= ext_cur;
			key_act_prev_reg <= key_any;
		end
	end

	// configuration registers
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			pin_sel_reg  <= REG_RESET;
			lowv_reg     <= REG_RESET;
			in_en_reg    <= REG_RESET;
			filt_sel_reg <= REG_RESET;
			key_en_reg   <= REG_RESET;
		end
		else
		begin
			if (wr_pin)
				pin_sel_reg <= wdata_in & PIN_SELECT_MASK;
			if (wr_lowv)
				lowv_reg <= lowv_wr_val;
			if (wr_en)
				in_en_reg <= wdata_in;
			if (wr_filt)
				filt_sel_reg <= wdata_in;
			if (wr_key)
				key_en_reg <= wdata_in;
		end
	end

	// request control registers and flags
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			for (int i = 0; i < NUM_SRC; i++)
				prio_reg[i] <= 3'h0;
			edge_dir_reg <= 4'h0;
			flag_reg     <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_SRC; i++)
				if (wr_ctrl[i])
					prio_reg[i] <= wdata_in[PRIO_MSB:PRIO_LSB];
			for (int i = 0; i < NUM_EXT; i++)
				if (wr_ctrl[i])
					edge_dir_reg[i] <= wdata_in[EDGE_DIR_BIT];
			flag_reg <= flag_next;
		end
	end

	// registered outputs
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			rdata_reg   <= 8'h00;
			irq_req_reg <= 1'b0;
			irq_src_reg <= 3'h0;
			irq_lvl_reg <= 3'h0;
			tx_pin_reg  <= 1'b1;
			tx_oe_reg   <= 1'b0;
		end
		else
		begin
			rdata_reg   <= rd_in ? rd_next : 8'h00;
			irq_req_reg <= win_req & ~(ack_in & ~swi_in);
			irq_src_reg <= win_src;
			irq_lvl_reg <= win_lvl;
			tx_pin_reg  <= serial_tx_data_in;
			tx_oe_reg   <= ~tx_open_drain | ~serial_tx_data_in;
		end
	end

	assign rdata_out            = rdata_reg;
	assign irq_req_out          = irq_req_reg;
	assign irq_src_out          = irq_src_reg;
	assign irq_level_out        = irq_lvl_reg;
	assign key_wake_out         = flag_reg[KEY_SRC];
	assign ext_lowv_out         = lowv_reg[LOWV_EXT_MSB:LOWV_EXT_LSB];
	assign serial_tx_pin_out    = tx_pin_reg;
	assign serial_tx_pin_oe_out = tx_oe_reg;

endmodule : ext_irq_ctrl

`default_nettype wire

// ---- verilog/ext_irq_filter.sv ----
// Purpose: three-sample digital noise filter for one external input
// Assumes: level_in is already synchronised to clk_in
// Notes: output only moves when all held samples agree

`timescale 1ns/100ps
`default_nettype none

module ext_irq_filter
	import ext_irq_pkg::*;
(
	input  wire logic clk_in,       // peripheral clock
	input  wire logic nrst_in,      // synchronous reset, active low
	input  wire logic tick_in,      // sampling clock enable pulse
	input  wire logic level_in,     // synchronised pin level
	output logic      filt_out      // filtered level
);

	logic [FILTER_DEPTH-1:0] samp_reg;
	logic                    filt_reg;
	wire                     all_high = &samp_reg;
	wire                     all_low  = ~|samp_reg;

	// sample shift and agreement check; idle level is high
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			samp_reg <= '1;
			filt_reg <= 1'b1;
		end
		else
		begin
			if (tick_in)
				samp_reg <= {samp_reg[FILTER_DEPTH-2:0], level_in};
			if (all_high)
				filt_reg <= 1'b1;
			else if (all_low)
				filt_reg <= 1'b0;
		end
	end

	assign filt_out = filt_reg;

endmodule : ext_irq_filter

`default_nettype wire
